//--- hdl/dpplc_pkg.sv
// constants, register map and types of the dual-purpose pin and low-power control
// -----------------------------------------------------------------------------
// Function
// - mode high: diag clock pin is probe/program clock; low: user I/O.
// - mode high: diag serial input takes serial data; low: user I/O.
// - mode high: diag serial output drives serial data; low: user I/O.
// - during checksum the serial output drives; afterwards back to user I/O.
// - mode input governs every multifunction diagnostic pin; held high for verification.
// - each probe pin outputs a selected internal node live; two together trace paths.
// - probe pins are probes only with mode high; otherwise user I/O.
// - probe capability can be disabled permanently and irreversibly.
// - global clock pins are buffered before clocking; unused ones are user I/O.
// - quadrant clock pins not used as register control are user I/O.
// - low-power high: all I/O tristated, input buffers off, core powered down.
// - low-power entry completes 800 ns after the low-power input rises.
// - low-power exit by driving input low; normal operation resumes 200 us later.
// -----------------------------------------------------------------------------
package dpplc_pkg;
	// pin indices
	localparam int PIN_COUNT = 11;
	localparam int PIN_DIAG_CLK = 0;
	localparam int PIN_SDI      = 1;
	localparam int PIN_SDO      = 2;
	localparam int PIN_PROBE_A  = 3;
	localparam int PIN_PROBE_B  = 4;
	localparam int PIN_GCLK_A   = 5;
	localparam int PIN_GCLK_B   = 6;
	localparam int PIN_QCLK0 = 7;
	localparam int QCLK_N    = 4;
	localparam int NODE_N    = 16;
	localparam int NODE_W    = 4;

	// register map
	localparam logic [7:0] CTRL_ADDR      = 8'h00;
	localparam logic [7:0] PROBE_SEL_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR    = 8'h08;
	localparam logic [6:0] CTRL_RESET     = 7'h00;
	localparam logic [7:0] PROBE_RESET    = 8'h00;
	localparam int CTRL_GCLK_A_BIT = 0;
	localparam int CTRL_GCLK_B_BIT = 1;
	localparam int CTRL_QCLK_LSB = 2;
	localparam int CTRL_LOCK_BIT = 6;

	// timing
	localparam int CLK_PERIOD_PS = 25000;
	localparam int LP_ENTRY_NS   = 800;
	localparam int LP_EXIT_US    = 200;
	localparam int LP_ENTRY_CYC  = (LP_ENTRY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LP_EXIT_CYC   = (LP_EXIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LP_CNT_W      = 14;
	// edges spent outside the counter: pin sample, sequencer flop, pad flop
	localparam int LP_PIPE_CYC   = 3;

	typedef enum logic [1:0] {
		LP_RUN,
		LP_ENTER,
		LP_DOWN,
		LP_WAKE
	} dpplc_lp_state_t;
endpackage : dpplc_pkg

//--- hdl/dpplc_pin_cell.sv
// one dual-purpose pad: user I/O or dedicated function, tristated in low power
`timescale 1ns/1ps
module dpplc_pin_cell (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// function select
	input  wire logic sel_dedicated,
	input  wire logic ded_drive,
	input  wire logic ded_out,
	input  wire logic lp_off,
	// user side
	input  wire logic user_out,
	input  wire logic user_oe,
	output logic      user_in,
	output logic      ded_in,
	// pad
	input  wire logic pad_in,
	output logic      pad_out,
	output logic      pad_oe_n
);
	wire next_drive = !lp_off && (sel_dedicated ? ded_drive : user_oe);
	wire next_out   = sel_dedicated ? ded_out : user_out;
	wire in_on      = !lp_off;

	always_ff @(posedge clk) begin
		if (srst) begin
			pad_oe_n <= 1'b1;
			pad_out  <= 1'b0;
			user_in  <= 1'b0;
			ded_in   <= 1'b0;
		end else begin
			pad_oe_n <= !next_drive;
			pad_out  <= next_out & next_drive;
			user_in  <= in_on & !sel_dedicated & pad_in;
			ded_in   <= in_on & sel_dedicated & pad_in;
		end
	end
endmodule : dpplc_pin_cell

//--- hdl/dpplc_lp_ctrl.sv
// low-power sequencer with fixed entry and exit latencies
`timescale 1ns/1ps
module dpplc_lp_ctrl #(
	parameter int EXIT_CYC = dpplc_pkg::LP_EXIT_CYC
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// low-power pin
	input  wire logic                   low_power_pin,
	// status and power control
	output dpplc_pkg::dpplc_lp_state_t  state,
	output logic                        io_off,
	output logic                        core_off
);
	// latencies count from the pin edge to the pads, so the pipeline comes off the count
	localparam logic [13:0] ENTRY_LAST = 14'(dpplc_pkg::LP_ENTRY_CYC - dpplc_pkg::LP_PIPE_CYC);
	localparam logic [13:0] EXIT_LAST  = 14'(EXIT_CYC - dpplc_pkg::LP_PIPE_CYC);

	dpplc_pkg::dpplc_lp_state_t next_state;
	logic [13:0]                count;
	wire  entry_done = (count == ENTRY_LAST);
	wire  exit_done  = (count == EXIT_LAST);

	always_comb begin
		next_state = state;
		case (state)
			dpplc_pkg::LP_RUN:   if (low_power_pin) next_state = dpplc_pkg::LP_ENTER;
			dpplc_pkg::LP_ENTER: if (!low_power_pin) next_state = dpplc_pkg::LP_RUN;
				else if (entry_done) next_state = dpplc_pkg::LP_DOWN;
			dpplc_pkg::LP_DOWN:  if (!low_power_pin) next_state = dpplc_pkg::LP_WAKE;
			dpplc_pkg::LP_WAKE:  if (low_power_pin) next_state = dpplc_pkg::LP_DOWN;
				else if (exit_done) next_state = dpplc_pkg::LP_RUN;
			default:             next_state = dpplc_pkg::LP_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state    <= dpplc_pkg::LP_RUN;
			count    <= 14'h0000;
			io_off   <= 1'b0;
			core_off <= 1'b0;
		end else begin
			state    <= next_state;
			count    <= (next_state == state) ? count + 14'h0001 : 14'h0000;
			io_off   <= (next_state == dpplc_pkg::LP_DOWN) || (next_state == dpplc_pkg::LP_WAKE);
			core_off <= (next_state == dpplc_pkg::LP_DOWN) || (next_state == dpplc_pkg::LP_WAKE);
		end
	end
endmodule : dpplc_lp_ctrl

//--- hdl/dpplc_top.sv
// top: APB registers, pin function selection, probes and low-power control
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module dpplc_top #(
	parameter int LP_EXIT_CYC = dpplc_pkg::LP_EXIT_CYC
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          srst,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// board control pins
	input  wire logic                          mode_pin,
	input  wire logic                          low_power_pin,
	// programming and probe logic
	input  wire logic                          diag_sdo_data,
	input  wire logic                          checksum_busy,
	input  wire logic [dpplc_pkg::NODE_N-1:0]  design_nodes,
	output logic                               diag_clock,
	output logic                               diag_sdi_data,
	// buffered clock and control nets
	output logic                               clock_a_net,
	output logic                               clock_b_net,
	output logic      [dpplc_pkg::QCLK_N-1:0]  quadrant_ctrl_net,
	// power control
	output logic                               input_buf_off,
	output logic                               core_power_down,
	// user logic side of every dual-purpose pin
	input  wire logic [dpplc_pkg::PIN_COUNT-1:0] user_out,
	input  wire logic [dpplc_pkg::PIN_COUNT-1:0] user_oe,
	output logic      [dpplc_pkg::PIN_COUNT-1:0] user_in,
	// pads: diag clock, serial in, serial out, probe a, probe b, clock a, clock b, quadrant 0..3
	input  wire logic [dpplc_pkg::PIN_COUNT-1:0] pad_in,
	output logic      [dpplc_pkg::PIN_COUNT-1:0] pad_out,
	output logic      [dpplc_pkg::PIN_COUNT-1:0] pad_oe_n
);
	// -------------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------------
	logic [6:0]  ctrl;
	logic [7:0]  probe_sel;
	logic        probe_a_val;
	logic        probe_b_val;

	dpplc_pkg::dpplc_lp_state_t lp_state;
	logic                       io_off;
	logic                       core_off;

	logic [dpplc_pkg::PIN_COUNT-1:0] ded_in;

	// -------------------------------------------------------------------------
	// APB decode
	// -------------------------------------------------------------------------
	wire access     = psel && penable && !pready;
	wire hit_ctrl   = (paddr == dpplc_pkg::CTRL_ADDR);
	wire hit_probe  = (paddr == dpplc_pkg::PROBE_SEL_ADDR);
	wire hit_status = (paddr == dpplc_pkg::STATUS_ADDR);
	wire mapped     = hit_ctrl || hit_probe || hit_status;
	wire wr_ctrl    = access && pwrite && hit_ctrl;
	wire wr_probe   = access && pwrite && hit_probe;

	// lock bit can only be set; once set it ignores writes of zero
	wire       probe_locked = ctrl[dpplc_pkg::CTRL_LOCK_BIT];
	wire [6:0] next_ctrl    = {probe_locked | pwdata[dpplc_pkg::CTRL_LOCK_BIT], pwdata[5:0]};

	wire [31:0] status_word = {26'h0000000, checksum_busy, probe_locked, lp_state, low_power_pin, mode_pin};
	wire [31:0] read_word   = hit_ctrl   ? {25'h0000000, ctrl} :
	                          hit_probe  ? {24'h000000, probe_sel} :
	                          hit_status ? status_word : 32'h00000000;

	always_ff @(posedge clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= access;
			pslverr <= access && !mapped;
			prdata  <= (access && !pwrite) ? read_word : 32'h00000000;
		end
	end

	// reset stands for power-on; no write can undo the lock
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl      <= dpplc_pkg::CTRL_RESET;
			probe_sel <= dpplc_pkg::PROBE_RESET;
		end else begin
			if (wr_ctrl)
				ctrl <= next_ctrl;
			if (wr_probe)
				probe_sel <= pwdata[7:0];
		end
	end

	// -------------------------------------------------------------------------
	// function selection per pin
	// -------------------------------------------------------------------------
	wire diag_on   = mode_pin;
	wire probe_on  = mode_pin && !probe_locked;
	wire sdo_on    = mode_pin || checksum_busy;

	wire [dpplc_pkg::PIN_COUNT-1:0] sel_ded = {
		ctrl[dpplc_pkg::CTRL_QCLK_LSB +: dpplc_pkg::QCLK_N],
		ctrl[dpplc_pkg::CTRL_GCLK_B_BIT],
		ctrl[dpplc_pkg::CTRL_GCLK_A_BIT],
		probe_on,
		probe_on,
		sdo_on,
		diag_on,
		diag_on
	};

	// only the sdo and probe pins drive when dedicated; the rest are inputs
	wire [dpplc_pkg::PIN_COUNT-1:0] ded_drive = {
		4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0
	};

	wire [dpplc_pkg::PIN_COUNT-1:0] ded_out = {
		4'h0, 1'b0, 1'b0, probe_b_val, probe_a_val, diag_sdo_data, 1'b0, 1'b0
	};

	// probe nodes are sampled once, then pass the pad flop: two cycles of latency, no glitches on the pad
	wire [dpplc_pkg::NODE_W-1:0] sel_a = probe_sel[dpplc_pkg::NODE_W-1:0];
	wire [dpplc_pkg::NODE_W-1:0] sel_b = probe_sel[2*dpplc_pkg::NODE_W-1:dpplc_pkg::NODE_W];

	always_ff @(posedge clk) begin
		if (srst) begin
			probe_a_val <= 1'b0;
			probe_b_val <= 1'b0;
		end else begin
			probe_a_val <= design_nodes[sel_a];
			probe_b_val <= design_nodes[sel_b];
		end
	end

	// -------------------------------------------------------------------------
	// pads
	// -------------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < dpplc_pkg::PIN_COUNT; gi++) begin : g_pin
			dpplc_pin_cell u_cell (
				.clk           (clk),
				.srst          (srst),
				.sel_dedicated (sel_ded[gi]),
				.ded_drive     (ded_drive[gi]),
				.ded_out       (ded_out[gi]),
				.lp_off        (io_off),
				.user_out      (user_out[gi]),
				.user_oe       (user_oe[gi]),
				.user_in       (user_in[gi]),
				.ded_in        (ded_in[gi]),
				.pad_in        (pad_in[gi]),
				.pad_out       (pad_out[gi]),
				.pad_oe_n      (pad_oe_n[gi])
			);
		end
	endgenerate

	// -------------------------------------------------------------------------
	// dedicated inputs: buffered onto their networks
	// -------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			diag_clock        <= 1'b0;
			diag_sdi_data     <= 1'b0;
			clock_a_net       <= 1'b0;
			clock_b_net       <= 1'b0;
			quadrant_ctrl_net <= 4'h0;
		end else begin
			diag_clock        <= ded_in[dpplc_pkg::PIN_DIAG_CLK];
			diag_sdi_data     <= ded_in[dpplc_pkg::PIN_SDI];
			clock_a_net       <= ded_in[dpplc_pkg::PIN_GCLK_A];
			clock_b_net       <= ded_in[dpplc_pkg::PIN_GCLK_B];
			quadrant_ctrl_net <= ded_in[dpplc_pkg::PIN_QCLK0 +: dpplc_pkg::QCLK_N];
		end
	end

	// -------------------------------------------------------------------------
	// low power
	// -------------------------------------------------------------------------
	dpplc_lp_ctrl #(
		.EXIT_CYC (LP_EXIT_CYC)
	) u_lp (
		.clk           (clk),
		.srst          (srst),
		.low_power_pin (low_power_pin),
		.state         (lp_state),
		.io_off        (io_off),
		.core_off      (core_off)
	);

	// input buffers and core follow the sequencer one cycle later
	always_ff @(posedge clk) begin
		if (srst) begin
			input_buf_off   <= 1'b0;
			core_power_down <= 1'b0;
		end else begin
			input_buf_off   <= io_off;
			core_power_down <= core_off;
		end
	end
endmodule : dpplc_top

//--- sim/dpplc_props.sv
// checker: pin function and low-power properties at the top ports
`timescale 1ns/1ps
module dpplc_props #(
	parameter int LP_EXIT_CYC = 20
) (
	// clock and reset
	input wire logic	clk,
	input wire logic	srst,
	// apb
	input wire logic	psel,
	input wire logic	penable,
	input wire logic [7:0]	paddr,
	input wire logic	pready,
	input wire logic	pslverr,
	// board, diag and power
	input wire logic	mode_pin,
	input wire logic	low_power_pin,
	input wire logic	diag_sdo_data,
	input wire logic	checksum_busy,
	input wire logic	diag_clock,
	input wire logic	input_buf_off,
	input wire logic	core_power_down,
	// pins
	input wire logic [dpplc_pkg::PIN_COUNT-1:0]	user_oe,
	input wire logic [dpplc_pkg::PIN_COUNT-1:0]	pad_in,
	input wire logic [dpplc_pkg::PIN_COUNT-1:0]	pad_out,
	input wire logic [dpplc_pkg::PIN_COUNT-1:0]	pad_oe_n
);
	logic [6:0]	hi_n;
	logic [15:0]	lo_n;
	logic	quiet;
	logic	acc;
	logic	mapped;
	// saturating run lengths of the low-power pin level
	always_ff @(posedge clk) begin
		if (srst) begin
			hi_n <= 7'h00;
			lo_n <= 16'h0000;
		end else begin
			hi_n <= !low_power_pin ? 7'h00 : hi_n + {6'h00, hi_n != 7'h7F};
			lo_n <= low_power_pin ? 16'h0000 : lo_n + {15'h0000, lo_n != 16'hFFFF};
		end
	end
	// pads only follow their function once power has settled
	assign quiet = lo_n >= 16'h0004 && !input_buf_off;
	assign acc = psel && penable && !pready;
	assign mapped = paddr == dpplc_pkg::CTRL_ADDR || paddr == dpplc_pkg::PROBE_SEL_ADDR
		|| paddr == dpplc_pkg::STATUS_ADDR;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_ready; acc |=> pready && pslverr == !$past(mapped); endproperty
	a_ready: assert property (p_ready) else $error("apb answer wrong");
	property p_user; !$past(mode_pin) && quiet && $past(quiet) |-> pad_oe_n[4:3] == ~$past(user_oe[4:3]); endproperty
	a_user: assert property (p_user) else $error("probe pads not user io");
	property p_idle; !$past(mode_pin) && !$past(mode_pin, 2) && quiet && $past(quiet, 2) |-> !diag_clock; endproperty
	a_idle: assert property (p_idle) else $error("diag clock active with mode low");
	property p_diag_clk; $past(mode_pin) && $past(mode_pin, 2) && quiet && $past(quiet, 2)
		|-> diag_clock == $past(pad_in[dpplc_pkg::PIN_DIAG_CLK], 2); endproperty
	a_diag_clk: assert property (p_diag_clk) else $error("diag clock not from pad");
	property p_sdo; $past(checksum_busy) && quiet && $past(quiet)
		|-> !pad_oe_n[2] && pad_out[2] == $past(diag_sdo_data); endproperty
	a_sdo: assert property (p_sdo) else $error("serial out not driving");
	property p_lp_off; input_buf_off && $past(low_power_pin) |-> core_power_down && &pad_oe_n; endproperty
	a_lp_off: assert property (p_lp_off) else $error("io active in low power");
	property p_entry; hi_n >= 7'h20 |-> input_buf_off; endproperty
	a_entry: assert property (p_entry) else $error("low power entry late");
	property p_exit; int'(lo_n) >= LP_EXIT_CYC |-> !input_buf_off; endproperty
	a_exit: assert property (p_exit) else $error("low power exit late");
	c_err: cover property (pready && pslverr);
	c_lp: cover property (input_buf_off);
	c_chk: cover property (checksum_busy && quiet);
endmodule : dpplc_props

bind dpplc_top dpplc_props #(.LP_EXIT_CYC(LP_EXIT_CYC)) u_props (.clk, .srst, .psel, .penable, .paddr, .pready,
	.pslverr, .mode_pin, .low_power_pin, .diag_sdo_data, .checksum_busy, .diag_clock, .input_buf_off,
	.core_power_down, .user_oe, .pad_in, .pad_out, .pad_oe_n);

//--- sim/dpplc_board_model.sv
// board and diagnostic tool on the far side of the pads
`timescale 1ns/1ps
module dpplc_board_model (
	// device pads
	input  wire logic [dpplc_pkg::PIN_COUNT-1:0]	pad_out,
	input  wire logic [dpplc_pkg::PIN_COUNT-1:0]	pad_oe_n,
	output logic      [dpplc_pkg::PIN_COUNT-1:0]	pad_in,
	// tool and board levels
	input  wire logic [dpplc_pkg::PIN_COUNT-1:0]	ext_val,
	input  wire logic	attach,
	output logic	mode_pin
);
	// tool holds mode high only while attached
	assign mode_pin = attach;
	// device wins where it drives, board level elsewhere
	assign pad_in = (pad_out & ~pad_oe_n) | (ext_val & pad_oe_n);
endmodule : dpplc_board_model

//--- sim/testbench.sv
// self-checking bench of the pin and low-power control
`timescale 1ns/1ps
module testbench;
	localparam int LPX = 20;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, low_power_pin = 0;
	logic diag_sdo_data = 0, checksum_busy = 0, attach = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [15:0] design_nodes = 16'h0000;
	logic [10:0] user_out = 11'h000, user_oe = 11'h000, ext_val = 11'h000, user_in, pad_in, pad_out, pad_oe_n;
	logic pready, pslverr, mode_pin, diag_clock, diag_sdi_data, clock_a_net, clock_b_net;
	logic input_buf_off, core_power_down;
	logic [3:0] quadrant_ctrl_net;
	int err_total = 0, comparisons = 0;
	always #12.5 clk = ~clk;
	dpplc_top #(.LP_EXIT_CYC(LPX)) i_dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .mode_pin, .low_power_pin, .diag_sdo_data, .checksum_busy, .design_nodes, .diag_clock,
		.diag_sdi_data, .clock_a_net, .clock_b_net, .quadrant_ctrl_net, .input_buf_off, .core_power_down,
		.user_out, .user_oe, .user_in, .pad_in, .pad_out, .pad_oe_n);
	dpplc_board_model i_board (.pad_out, .pad_oe_n, .pad_in, .ext_val, .attach, .mode_pin);
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 8);
		if (n >= 8) begin err_total++; test_done(); end
		r = prdata; e = pslverr; psel <= 0; penable <= 0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1, a, d, r, e);
	endtask : wr
	task t_regs;
		logic [31:0] r;
		logic e;
		apb(0, dpplc_pkg::CTRL_ADDR, 0, r, e); chk("ctrl reset", r, 32'h0);
		wr(dpplc_pkg::PROBE_SEL_ADDR, 32'h52);
		apb(0, dpplc_pkg::PROBE_SEL_ADDR, 0, r, e); chk("probe sel", r, 32'h52);
		apb(1, 8'h0C, 32'h1, r, e); chk("unmapped write", e, 1);
		apb(0, 8'h0C, 0, r, e); chk("unmapped err", e, 1); chk("unmapped data", r, 32'h0);
		wr(dpplc_pkg::STATUS_ADDR, 32'hFF);
		apb(0, dpplc_pkg::STATUS_ADDR, 0, r, e); chk("status", r, 32'h0);
		$display("regs test done");
	endtask : t_regs
	task t_clocks;
		wr(dpplc_pkg::CTRL_ADDR, 32'h3F);
		ext_val <= 11'h5A0;
		cyc(4);
		chk("clock a", clock_a_net, 1);
		chk("clock b", clock_b_net, 0);
		chk("quadrant", quadrant_ctrl_net, 4'hB);
		wr(dpplc_pkg::CTRL_ADDR, 32'h0);
		cyc(4);
		chk("clock a off", clock_a_net, 0);
		chk("clock user", user_in[10:5], 6'h2D);
		$display("clock pin test done");
	endtask : t_clocks
	task t_diag;
		logic [31:0] r;
		logic e;
		attach <= 1; ext_val <= 11'h003; design_nodes <= 16'h0024; diag_sdo_data <= 1;
		cyc(4);
		chk("diag clock", diag_clock, 1);
		chk("diag sdi", diag_sdi_data, 1);
		chk("probe out", pad_out[4:3], 2'b11);
		chk("probe oe", pad_oe_n[4:3], 2'b00);
		chk("sdo mode", {pad_oe_n[2], pad_out[2]}, 2'b01);
		checksum_busy <= 1; attach <= 0;
		cyc(3);
		chk("sdo drive", {pad_oe_n[2], pad_out[2]}, 2'b01);
		checksum_busy <= 0; attach <= 0; user_oe <= 11'h018; user_out <= 11'h008;
		cyc(4);
		chk("sdo user", pad_oe_n[2], 1);
		chk("probe user", pad_out[4:3], 2'b01);
		chk("diag clk user", user_in[1:0], 2'b11);
		wr(dpplc_pkg::CTRL_ADDR, 32'h40);
		wr(dpplc_pkg::CTRL_ADDR, 32'h0);
		attach <= 1;
		cyc(4);
		chk("locked probe", pad_out[4:3], 2'b01);
		apb(0, dpplc_pkg::STATUS_ADDR, 0, r, e); chk("lock status", r, 32'h11);
		$display("diag pin test done");
	endtask : t_diag
	task t_lp;
		logic [31:0] r;
		logic e;
		srst <= 1; attach <= 0; user_oe <= 11'h7FF;
		cyc(2);
		srst <= 0; low_power_pin <= 1;
		cyc(10);
		low_power_pin <= 0;
		cyc(2);
		apb(0, dpplc_pkg::STATUS_ADDR, 0, r, e); chk("lp abort", r, 32'h0);
		low_power_pin <= 1;
		cyc(32);
		chk("lp early", input_buf_off, 0);
		chk("lp inputs on", user_in, 11'h008);
		cyc(1);
		chk("lp bufs", {input_buf_off, core_power_down}, 2'b11);
		chk("lp pads", pad_oe_n, 11'h7FF);
		chk("lp inputs", user_in, 11'h000);
		apb(0, dpplc_pkg::STATUS_ADDR, 0, r, e); chk("lp state", r, 32'hA);
		low_power_pin <= 0;
		cyc(LPX);
		chk("lp hold", input_buf_off, 1);
		cyc(1);
		chk("lp resume", input_buf_off, 0);
		chk("lp pads back", pad_oe_n, 11'h000);
		$display("low power test done");
	endtask : t_lp
	initial begin
		cyc(2);
		srst <= 0;
		t_regs;
		t_clocks;
		t_diag;
		t_lp;
		test_done;
	end
endmodule : testbench
